/* File: fsc_pkg.sv */
// Package for the flash security command sequencer.
// Assumes a single core clock domain; shared by the sequencer top, its checker and the testbench.
package fsc_pkg;

  // Wishbone register map (word offsets as byte addresses)
  localparam logic [7:0] FSC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] FSC_CMD_ADDR = 8'h04;
  localparam logic [7:0] FSC_DATA_ADDR = 8'h08;
  localparam logic [7:0] FSC_STAT_ADDR = 8'h0C;
  localparam logic [7:0] FSC_RDATA_ADDR = 8'h10;

  // Control/status bit positions
  localparam int FSC_SEL_BIT = 0;
  localparam int FSC_RDY_BIT = 2;
  localparam int FSC_TMO_BIT = 5;
  localparam int FSC_SEC_BIT = 8;
  localparam int FSC_PGM_BIT = 9;

  // Command addresses and data
  localparam logic [15:0] FSC_UNLOCK1_ADDR = 16'hAAA8;
  localparam logic [15:0] FSC_UNLOCK2_ADDR = 16'h5554;
  localparam logic [15:0] FSC_ZERO_ADDR = 16'h0000;
  localparam logic [3:0] FSC_LOW_NIB = 4'h0;
  localparam logic [7:0] FSC_CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FSC_CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] FSC_CMD_RESET = 8'hF0;
  localparam logic [7:0] FSC_CMD_PROG = 8'hA0;
  localparam logic [7:0] FSC_CMD_ERASE = 8'h80;
  localparam logic [7:0] FSC_CMD_LOCK = 8'h9A;
  localparam logic [7:0] FSC_CMD_QUERY = 8'h90;
  localparam logic [7:0] FSC_CMD_CHIP = 8'h10;
  localparam logic [7:0] FSC_CMD_SECTOR = 8'h30;
  localparam logic [7:0] FSC_CMD_ZERO = 8'h00;
  localparam logic [3:0] FSC_LOCK_LAST = 4'hA;
  // Lock counter values at cycle six and at the sector address cycle
  localparam logic [3:0] FSC_LOCK_FIRST = 4'h5;
  localparam logic [3:0] FSC_LOCK_ADDR_CYC = 4'h6;

  // Fixed answer for programmer reads while secured; value arbitrary
  localparam logic [31:0] FSC_SECURED_CODE = 32'h0000_005A;

  // Embedded algorithm time limit
  localparam int FSC_CLK_MHZ = 25;
  localparam int FSC_LIMIT_US = 100;
  localparam int FSC_LIMIT_CYC = FSC_LIMIT_US * FSC_CLK_MHZ;

  // Command write carrier toward the sequencer
  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] data;
  } fsc_cmd_type;

  // Sequencer states, one-hot
  typedef enum logic [8:0] {
    FSC_ST_READ = 9'h001,
    FSC_ST_UNL1 = 9'h002,
    FSC_ST_UNL2 = 9'h004,
    FSC_ST_PROG = 9'h008,
    FSC_ST_ER3 = 9'h010,
    FSC_ST_ER4 = 9'h020,
    FSC_ST_ER5 = 9'h040,
    FSC_ST_QUERY = 9'h080,
    FSC_ST_EMB = 9'h100
  } fsc_state_type;

  // Embedded operation kinds
  typedef enum logic [5:0] {
    FSC_OP_NONE = 6'h01,
    FSC_OP_PROG = 6'h02,
    FSC_OP_CHIP = 6'h04,
    FSC_OP_SECON = 6'h08,
    FSC_OP_SECOFF = 6'h10,
    FSC_OP_LOCK = 6'h20
  } fsc_op_type;

endpackage

/* File: fsc_sequencer.sv */
// Flash security command sequencer: decodes command write sequences,
// runs embedded program/erase/secure/unsecure with a flash macro handshake.
// Assumes the flash macro answers op_start with op_done and a pass/fail level.
`timescale 1ns/10ps
`default_nettype none

// Function
// RULE_01: Security bit separate; blocks programmer array reads.
// RULE_02: Secure command programs then verifies security bit.
// RULE_03: Command writes discarded during secure/unsecure.
// RULE_04: Hardware reset aborts embedded operation immediately.
// RULE_05: Host keeps select bit stable during operation.
// RULE_06: Successful secure/unsecure returns to read mode.
// RULE_07: CPU reads array when secured, select cleared.
// RULE_08: Failure stays embedded, shown by status flags.
// RULE_09: Secured programmer reads return fixed code.
// RULE_10: Unsecure erases array then security bit.
// RULE_11: Array erase failure keeps part secured.
// RULE_12: Unsecure erases locked sectors, keeps locks.
// RULE_13: Full erase with select set means unsecure.
// RULE_14: Sector erase while secured ends immediately.
// RULE_15: Commands start with two unlock writes.
// RULE_16: F0H three-cycle or one-cycle return to read. After failure the code takes only F0H at a zero low nibble.
// RULE_17: Word write: A0H then address and word.
// RULE_18: Erase: 80H, second unlock pair, final cycle.
// RULE_19: Sector lock: 9AH, unlock pair, ten cycles.
// RULE_20: Lock query: 90H, then read lock state.
// RULE_21: Secure: A0H then code byte at zero.
// RULE_22: Select bit resets to zero.
// RULE_23: Ready flag low while busy and after failure.
// RULE_24: Timeout flag set when time limit exceeded.
// RULE_25: Host sets select bit before secure command.
// RULE_26: Mismatched write abandons sequence to read mode.
module fsc_sequencer
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Array read path
  input wire logic programmer_mode_in,
  input wire logic [31:0] array_rdata_in,
  input wire logic lock_state_in,
  // Flash macro operation handshake
  output logic op_start_out,
  output logic [5:0] op_kind_out,
  output logic [23:0] op_addr_out,
  output logic [31:0] op_data_out,
  input wire logic op_done_in,
  input wire logic op_fail_in,
  // Security bit state and ready/busy flag
  output logic secured_out,
  output logic ready_busy_flag_out
);
  import fsc_pkg::*;

  // Sequencer state and latched command
  fsc_state_type state_q;
  fsc_op_type op_q;
  fsc_cmd_type cmd_q;
  logic security_select_bit_q;
  logic secured_q;
  logic timeout_flag_q;
  logic ready_q;
  logic fail_q;
  logic phase2_q;
  logic [3:0] lock_cnt_q;
  logic [23:0] lock_addr_q;
  logic [15:0] lim_cnt_q;
  logic [31:0] rdata_q;
  logic cmd_go_q;
  // Start strobe from the decoder; the port copy lags it one clock so
  // that kind and operands are loaded in the same clock as the strobe
  logic start_q;
  // Combinational decode of the current bus request and command
  logic req;
  logic wr_cmd;
  logic [7:0] cdat;
  logic [15:0] cadr;
  logic a_unl1;
  logic a_unl2;

  // Bus request decode; ack high one cycle, then low
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_cmd = req && wb_we_in && (wb_adr_in == FSC_CMD_ADDR);
  assign cdat = cmd_q.data[7:0];
  assign cadr = cmd_q.addr[15:0];
  assign a_unl1 = (cadr == FSC_UNLOCK1_ADDR);
  assign a_unl2 = (cadr == FSC_UNLOCK2_ADDR);

  // Single-cycle ack, every address answered
  // Masking req with ack keeps one request from being taken twice
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  // Read mux; unmapped addresses read zero
  // Values are those of the take edge, held until the next read
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (req && !wb_we_in) begin
      wb_dat_out <= 32'h0000_0000;
      case (wb_adr_in)
        FSC_CTRL_ADDR: begin
          wb_dat_out[FSC_SEL_BIT] <= security_select_bit_q;
          wb_dat_out[FSC_RDY_BIT] <= ready_q; // RULE_23
        end
        FSC_STAT_ADDR: begin
          wb_dat_out[FSC_RDY_BIT] <= ready_q;
          wb_dat_out[FSC_TMO_BIT] <= timeout_flag_q; // RULE_24
          wb_dat_out[FSC_SEC_BIT] <= secured_q;
          wb_dat_out[FSC_PGM_BIT] <= programmer_mode_in;
        end
        FSC_RDATA_ADDR: begin
          wb_dat_out <= rdata_q;
        end
        default: begin
          wb_dat_out <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Select bit; steers program/erase to array or security logic
  // Not locked while busy: the host must keep it steady through a run
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      security_select_bit_q <= 1'b0; // RULE_22
    end else if (req && wb_we_in && wb_adr_in == FSC_CTRL_ADDR && wb_sel_in[0]) begin
      security_select_bit_q <= wb_dat_in[FSC_SEL_BIT]; // RULE_05 RULE_25
    end
  end

  // Command latch: data register then command address write fires
  // Writes while busy land here but reach the macro only at a start
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_q <= '0;
      cmd_go_q <= 1'b0;
    end else begin
      cmd_go_q <= wr_cmd;
      if (req && wb_we_in && wb_adr_in == FSC_DATA_ADDR) begin
        cmd_q.data <= wb_dat_in;
      end
      if (wr_cmd) begin
        cmd_q.addr <= wb_dat_in[23:0];
      end
    end
  end

  // Array read path with security gating
  // One clock behind the pins; bus reads see only the gated copy
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (state_q == FSC_ST_QUERY) begin
      rdata_q <= {31'h0000_0000, lock_state_in}; // RULE_20
    end else if (secured_q && programmer_mode_in) begin
      rdata_q <= FSC_SECURED_CODE; // RULE_01 RULE_09
    end else begin
      rdata_q <= array_rdata_in; // RULE_07
    end
  end

  // Command sequence decoder and embedded operation control
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= FSC_ST_READ; // RULE_04
      op_q <= FSC_OP_NONE;
      ready_q <= 1'b1;
      fail_q <= 1'b0;
      phase2_q <= 1'b0;
      lock_cnt_q <= 4'h0;
      lock_addr_q <= 24'h00_0000;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        // Idle: only the first unlock write starts a sequence
        FSC_ST_READ: begin
          if (cmd_go_q) begin
            if (a_unl1 && cdat == FSC_CMD_UNLOCK1) begin
              state_q <= FSC_ST_UNL1; // RULE_15
            end
          end
        end
        // Second unlock write must follow directly
        FSC_ST_UNL1: begin
          if (cmd_go_q) begin
            state_q <= (a_unl2 && cdat == FSC_CMD_UNLOCK2) ? FSC_ST_UNL2 : FSC_ST_READ; // RULE_26
          end
        end
        // Third cycle selects the command family
        FSC_ST_UNL2: begin
          if (cmd_go_q) begin
            state_q <= FSC_ST_READ; // RULE_16 RULE_26
            if (a_unl1 && cdat == FSC_CMD_PROG) begin
              state_q <= FSC_ST_PROG; // RULE_17 RULE_21
            end else if (a_unl1 && (cdat == FSC_CMD_ERASE || cdat == FSC_CMD_LOCK)) begin
              op_q <= (cdat == FSC_CMD_LOCK) ? FSC_OP_LOCK : FSC_OP_CHIP; // RULE_18 RULE_19
              phase2_q <= 1'b0;
              state_q <= FSC_ST_ER3;
            end else if (a_unl1 && cdat == FSC_CMD_QUERY) begin
              state_q <= FSC_ST_QUERY; // RULE_20
            end
          end
        end
        // Fourth cycle: program word, or security bit when steered there
        FSC_ST_PROG: begin
          if (cmd_go_q) begin
            state_q <= FSC_ST_EMB;
            ready_q <= 1'b0;
            start_q <= 1'b1;
            // Select set and address zero reach the security bit; code not checked
            if (security_select_bit_q && cadr == FSC_ZERO_ADDR) begin
              op_q <= FSC_OP_SECON; // RULE_02
            end else begin
              op_q <= FSC_OP_PROG;
            end
          end
        end
        // Erase and lock share the second unlock pair
        FSC_ST_ER3: begin
          if (cmd_go_q) begin
            state_q <= (a_unl1 && cdat == FSC_CMD_UNLOCK1) ? FSC_ST_ER4 : FSC_ST_READ; // RULE_26
          end
        end
        // Cycle five; the lock counter is primed for cycle six
        FSC_ST_ER4: begin
          if (cmd_go_q) begin
            state_q <= (a_unl2 && cdat == FSC_CMD_UNLOCK2) ? FSC_ST_ER5 : FSC_ST_READ;
            lock_cnt_q <= FSC_LOCK_FIRST;
          end
        end
        // Final erase cycle, or cycles six to ten of a lock
        FSC_ST_ER5: begin
          if (cmd_go_q) begin
            state_q <= FSC_ST_READ;
            if (op_q == FSC_OP_LOCK) begin
              // Cycles 6..10 of the lock sequence
              lock_cnt_q <= lock_cnt_q + 4'h1;
              state_q <= FSC_ST_ER5;
              // Cycle seven carries the sector address
              if (lock_cnt_q == FSC_LOCK_ADDR_CYC) begin
                lock_addr_q <= cmd_q.addr; // RULE_19
              end
              // Cycles eight to ten need a zero low nibble
              if (lock_cnt_q == FSC_LOCK_FIRST && !(a_unl1 && cdat == FSC_CMD_LOCK)) begin
                state_q <= FSC_ST_READ;
              end else if (lock_cnt_q > FSC_LOCK_ADDR_CYC && cmd_q.addr[3:0] != FSC_LOW_NIB) begin
                state_q <= FSC_ST_READ;
              end else if (lock_cnt_q == FSC_LOCK_LAST - 4'h1) begin
                state_q <= FSC_ST_EMB;
                ready_q <= 1'b0;
                start_q <= 1'b1;
              end
            end else if (a_unl1 && cdat == FSC_CMD_CHIP) begin
              state_q <= FSC_ST_EMB;
              ready_q <= 1'b0;
              start_q <= 1'b1;
              phase2_q <= 1'b0;
              op_q <= security_select_bit_q ? FSC_OP_SECOFF : FSC_OP_CHIP; // RULE_13 RULE_10
            end else if (cdat == FSC_CMD_SECTOR && !secured_q) begin
              state_q <= FSC_ST_EMB;
              ready_q <= 1'b0;
              start_q <= 1'b1;
              op_q <= FSC_OP_CHIP;
            end else if (cdat == FSC_CMD_SECTOR) begin
              state_q <= FSC_ST_READ; // RULE_14
            end
          end
        end
        // Lock query holds until a reset command
        FSC_ST_QUERY: begin
          // Lock state follows read address; leave only by reset command
          if (cmd_go_q && cdat == FSC_CMD_RESET) begin
            state_q <= FSC_ST_READ;
          end
        end
        FSC_ST_EMB: begin // RULE_03
          // Writes while busy are dropped; after failure only F0H leaves
          if (fail_q) begin
            if (cmd_go_q && cdat == FSC_CMD_RESET && cmd_q.addr[3:0] == FSC_LOW_NIB) begin
              state_q <= FSC_ST_READ; // RULE_08
              fail_q <= 1'b0;
              ready_q <= 1'b1;
            end
          // Running out of time counts as a failed step
          end else if (op_done_in || lim_cnt_q == FSC_LIMIT_CYC[15:0]) begin
            if (op_fail_in || lim_cnt_q == FSC_LIMIT_CYC[15:0]) begin
              fail_q <= 1'b1; // RULE_08 RULE_11
            end else if (op_q == FSC_OP_SECOFF && !phase2_q) begin
              phase2_q <= 1'b1; // RULE_10 RULE_12
              start_q <= 1'b1;
            end else begin
              state_q <= FSC_ST_READ; // RULE_06
              ready_q <= 1'b1;
            end
          end
        end
        // Illegal one-hot codes fall back to idle
        default: begin
          state_q <= FSC_ST_READ;
        end
      endcase
    end
  end

  // Time limit counter and timeout flag
  // Counting stops at the limit, so the flag cannot wrap back to zero
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lim_cnt_q <= 16'h0000;
      timeout_flag_q <= 1'b0;
    end else if (state_q != FSC_ST_EMB || start_q) begin
      lim_cnt_q <= 16'h0000;
      timeout_flag_q <= 1'b0;
    end else if (!fail_q && lim_cnt_q != FSC_LIMIT_CYC[15:0]) begin
      lim_cnt_q <= lim_cnt_q + 16'h0001;
    end else if (!fail_q) begin
      timeout_flag_q <= 1'b1; // RULE_24
    end
  end

  // Security bit state, changed only by successful embedded steps
  // Volatile copy: a hardware reset clears it with everything else
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      secured_q <= 1'b0;
    end else if (state_q == FSC_ST_EMB && !fail_q && op_done_in && !op_fail_in) begin
      if (op_q == FSC_OP_SECON) begin
        secured_q <= 1'b1; // RULE_02
      end else if (op_q == FSC_OP_SECOFF && phase2_q) begin
        secured_q <= 1'b0; // RULE_11
      end
    end
  end

  // Operation descriptor toward the flash macro, loaded with the strobe
  // so that writes dropped while busy never disturb a running step
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_start_out <= 1'b0;
      op_kind_out <= FSC_OP_NONE;
      op_addr_out <= 24'h00_0000;
      op_data_out <= 32'h0000_0000;
      secured_out <= 1'b0;
      ready_busy_flag_out <= 1'b1;
    end else begin
      op_start_out <= start_q; // RULE_03
      if (start_q) begin
        op_kind_out <= (op_q == FSC_OP_SECOFF && phase2_q) ? FSC_OP_SECON : op_q;
        op_addr_out <= (op_q == FSC_OP_LOCK) ? lock_addr_q : cmd_q.addr;
        op_data_out <= cmd_q.data;
      end
      secured_out <= secured_q;
      ready_busy_flag_out <= ready_q;
    end
  end

endmodule
`default_nettype wire

/* File: fsc_flash_model.sv */
// Flash macro model answering the sequencer's operation handshake.
// Assumes the bench sets step length and pass/fail per scenario.
`timescale 1ns/10ps
`default_nettype none
module fsc_flash_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Step request and bench controls
  input wire logic op_start_in,
  input wire logic [15:0] delay_in,
  input wire logic fail_mode_in,
  // Answers toward the sequencer
  output logic op_done_out,
  output logic op_fail_out,
  output logic [31:0] array_rdata_out,
  output logic lock_state_out
);
  logic [15:0] cnt_q;
  // Step timer; reset drops any step in flight
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 16'h0000;
      op_done_out <= 1'b0;
      op_fail_out <= 1'b0;
    end else begin
      op_done_out <= (cnt_q == 16'h0001);
      // Fail level only counts with done, so it toggles otherwise
      op_fail_out <= (cnt_q == 16'h0001) ? fail_mode_in : ~op_fail_out;
      if (op_start_in) begin
        cnt_q <= delay_in;
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
  // Array content and lock state survive every erase step
  assign array_rdata_out = 32'h1357_9BDF;
  assign lock_state_out = 1'b1;
endmodule
`default_nettype wire

/* File: fsc_sequencer_checker.sv */
// Checker on the sequencer top ports.
// Assumes one clock and an async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fsc_sequencer_checker
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Observed ports
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic programmer_mode_in,
  input wire logic op_start_out,
  input wire logic [5:0] op_kind_out,
  input wire logic op_done_in,
  input wire logic op_fail_in,
  input wire logic secured_out,
  input wire logic ready_busy_flag_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  // Request taken, and a failed flash step
  sequence s_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_fail;
    op_done_in && op_fail_in;
  endsequence
  property p_ack; s_taken |=> wb_ack_out ##1 !wb_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  property p_busy; op_start_out |-> ##[0:1] !ready_busy_flag_out; endproperty
  a_busy: assert property (p_busy) else $error("ready high while step runs");
  property p_fail; s_fail ##0 !ready_busy_flag_out |=> !ready_busy_flag_out [*2]; endproperty
  a_fail: assert property (p_fail) else $error("ready rose after failure");
  property p_pass;
    op_done_in && !op_fail_in && !ready_busy_flag_out |-> ##[1:4]
      (ready_busy_flag_out || op_start_out);
  endproperty
  a_pass: assert property (p_pass) else $error("no return to read after pass");
  property p_keep;
    s_fail ##0 (op_kind_out == FSC_OP_SECOFF && secured_out) |=>
      (secured_out && !op_start_out) [*4];
  endproperty
  a_keep: assert property (p_keep) else $error("security bit erased after failure");
  property p_code;
    s_taken ##0 (!wb_we_in && wb_adr_in == FSC_RDATA_ADDR && programmer_mode_in
      && secured_out) |=> wb_dat_out == FSC_SECURED_CODE;
  endproperty
  a_code: assert property (p_code) else $error("programmer read not fixed code");
  property p_rst; $rose(nrst_in) |-> ready_busy_flag_out && !op_start_out; endproperty
  a_rst: assert property (p_rst) else $error("reset left operation running");
  property p_drop;
    !ready_busy_flag_out && !op_done_in && !$past(op_done_in) && !$past(op_done_in, 2)
      && !$past(op_done_in, 3) |=> !op_start_out;
  endproperty
  a_drop: assert property (p_drop) else $error("command acted on while busy");
endmodule
bind fsc_sequencer fsc_sequencer_checker u_fsc_sequencer_checker (.core_clk_in, .nrst_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .programmer_mode_in,
  .op_start_out, .op_kind_out, .op_done_in, .op_fail_in, .secured_out, .ready_busy_flag_out);
`default_nettype wire

/* File: test_fsc_sequencer.sv */
// Testbench: Wishbone host tasks drive command sequences.
// Assumes the flash model answers each started step.
`timescale 1ns/10ps
`default_nettype none
module test_fsc_sequencer;
  import fsc_pkg::*;
  logic clk, nrst, cyc, stb, we, pmode, ack, start, done, fail, sec, rdy, lock, fmode;
  logic [7:0] adr;
  logic [31:0] wd, rd, arr, odat, q, ldat;
  logic [5:0] kind, lkind;
  logic [23:0] oadr, ladr;
  logic [15:0] dly;
  int starts = 0, mismatches = 0, total_checks = 0;
  fsc_sequencer u_fsc_sequencer (.core_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd),
    .wb_dat_out(rd), .wb_ack_out(ack), .programmer_mode_in(pmode), .array_rdata_in(arr),
    .lock_state_in(lock), .op_start_out(start), .op_kind_out(kind), .op_addr_out(oadr),
    .op_data_out(odat), .op_done_in(done), .op_fail_in(fail), .secured_out(sec),
    .ready_busy_flag_out(rdy));
  fsc_flash_model u_fsc_flash_model (.core_clk_in(clk), .nrst_in(nrst), .op_start_in(start),
    .delay_in(dly), .fail_mode_in(fmode), .op_done_out(done), .op_fail_out(fail),
    .array_rdata_out(arr), .lock_state_out(lock));
  // Record each step handed to the flash
  always @(posedge clk) begin
    if (start === 1'b1) begin
      starts++;
      lkind <= kind;
      ladr <= oadr;
      ldat <= odat;
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // A used-up wait counts as a mismatch and ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    bound(n, 50);
  endtask
  task automatic cmd(input logic [23:0] a, input logic [31:0] d);
    xfer(1'b1, FSC_DATA_ADDR, d);
    xfer(1'b1, FSC_CMD_ADDR, {8'h00, a});
  endtask
  task automatic unlock();
    cmd({8'h00, FSC_UNLOCK1_ADDR}, {24'h000000, FSC_CMD_UNLOCK1});
    cmd({8'h00, FSC_UNLOCK2_ADDR}, {24'h000000, FSC_CMD_UNLOCK2});
  endtask
  task automatic seq3(input logic [7:0] c);
    unlock();
    cmd({8'h00, FSC_UNLOCK1_ADDR}, {24'h000000, c});
  endtask
  task automatic erase6(input logic [23:0] a, input logic [7:0] c);
    seq3(FSC_CMD_ERASE);
    unlock();
    cmd(a, {24'h000000, c});
  endtask
  task automatic flags(input logic r, input logic s);
    xfer(1'b0, FSC_STAT_ADDR, 32'h0);
    chk("ready_secured", {30'h0, r, s}, {30'h0, q[FSC_RDY_BIT], q[FSC_SEC_BIT]});
  endtask
  task automatic steps(input int n, input logic [5:0] k);
    chk("steps", 32'(n), 32'(starts));
    chk("kind", {26'h0, k}, {26'h0, lkind});
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      xfer(1'b0, FSC_STAT_ADDR, 32'h0);
      n++;
    end while (q[FSC_RDY_BIT] !== 1'b1 && n < 100);
    bound(n, 100);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 500);
    bound(n, 500);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    {cyc, stb, we, pmode, fmode} = 5'h00;
    adr = 8'h00;
    wd = 32'h0;
    dly = 16'h0014;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    flags(1'b1, 1'b0);
    xfer(1'b0, FSC_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0000_0004, q);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    seq3(FSC_CMD_PROG);
    cmd(24'h000120, 32'hCAFE_0001);
    wait_ready();
    steps(1, FSC_OP_PROG);
    chk("prog_data", 32'hCAFE_0001, ldat);
    chk("prog_addr", 32'h0000_0120, {8'h00, ladr});
    cmd({8'h00, FSC_UNLOCK1_ADDR}, {24'h000000, FSC_CMD_UNLOCK1});
    cmd({8'h00, FSC_UNLOCK2_ADDR}, 32'h0000_0077);
    cmd({8'h00, FSC_UNLOCK1_ADDR}, {24'h000000, FSC_CMD_PROG});
    cmd(24'h000200, 32'h0000_0002);
    steps(1, FSC_OP_PROG);
    $display("test program done");
    dly <= 16'h00C8;
    xfer(1'b1, FSC_CTRL_ADDR, 32'h0000_0001);
    seq3(FSC_CMD_PROG);
    cmd({8'h00, FSC_ZERO_ADDR}, FSC_SECURED_CODE);
    seq3(FSC_CMD_PROG);
    cmd(24'h000300, 32'h0000_0001);
    wait_ready();
    steps(2, FSC_OP_SECON);
    flags(1'b1, 1'b1);
    pmode <= 1'b1;
    xfer(1'b0, FSC_RDATA_ADDR, 32'h0);
    chk("programmer_read", FSC_SECURED_CODE, q);
    pmode <= 1'b0;
    xfer(1'b1, FSC_CTRL_ADDR, 32'h0);
    xfer(1'b0, FSC_RDATA_ADDR, 32'h0);
    chk("cpu_read", 32'h1357_9BDF, q);
    erase6(24'h008000, FSC_CMD_SECTOR);
    flags(1'b1, 1'b1);
    steps(2, FSC_OP_SECON);
    $display("test secure done");
    dly <= 16'h0014;
    fmode <= 1'b1;
    xfer(1'b1, FSC_CTRL_ADDR, 32'h0000_0001);
    erase6({8'h00, FSC_UNLOCK1_ADDR}, FSC_CMD_CHIP);
    wait_done();
    flags(1'b0, 1'b1);
    steps(3, FSC_OP_SECOFF);
    cmd(24'h000050, {24'h000000, FSC_CMD_RESET});
    flags(1'b1, 1'b1);
    fmode <= 1'b0;
    erase6({8'h00, FSC_UNLOCK1_ADDR}, FSC_CMD_CHIP);
    wait_ready();
    steps(5, FSC_OP_SECON);
    flags(1'b1, 1'b0);
    xfer(1'b1, FSC_CTRL_ADDR, 32'h0);
    $display("test unsecure done");
    seq3(FSC_CMD_LOCK);
    unlock();
    cmd({8'h00, FSC_UNLOCK1_ADDR}, {24'h000000, FSC_CMD_LOCK});
    cmd(24'h010000, 32'h0);
    repeat (3) cmd(24'h000040, 32'h0);
    wait_ready();
    steps(6, FSC_OP_LOCK);
    chk("lock_addr", 32'h0001_0000, {8'h00, ladr});
    seq3(FSC_CMD_QUERY);
    xfer(1'b0, FSC_RDATA_ADDR, 32'h0);
    chk("lock_query_result", 32'h0000_0001, q);
    seq3(FSC_CMD_RESET);
    xfer(1'b0, FSC_RDATA_ADDR, 32'h0);
    chk("read_back", 32'h1357_9BDF, q);
    $display("test lock done");
    dly <= 16'h0BB8;
    seq3(FSC_CMD_PROG);
    cmd(24'h000400, 32'h0000_0001);
    repeat (FSC_LIMIT_CYC + 100) @(posedge clk);
    xfer(1'b0, FSC_STAT_ADDR, 32'h0);
    chk("timeout_flag", 32'h2, {30'h0, q[FSC_TMO_BIT], q[FSC_RDY_BIT]});
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    flags(1'b1, 1'b0);
    chk("timeout_clear", 32'h0, {31'h0, q[FSC_TMO_BIT]});
    $display("test abort done");
    print_verdict();
  end
endmodule
`default_nettype wire
